// ---- shared/sleep_wake_pkg.sv ----
// Package with register map, field layouts and state encodings of the sleep and wake controller.
package sleep_wake_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets on the APB slave
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_REQ1      = 8'h00;
   localparam logic [7:0] OFF_REQ2      = 8'h04;
   localparam logic [7:0] OFF_REQ3      = 8'h08;
   localparam logic [7:0] OFF_REQ4      = 8'h0C;
   localparam logic [7:0] OFF_EN1       = 8'h10;
   localparam logic [7:0] OFF_EN2       = 8'h14;
   localparam logic [7:0] OFF_EN3       = 8'h18;
   localparam logic [7:0] OFF_EN4       = 8'h1C;
   localparam logic [7:0] OFF_INTCTL    = 8'h20;
   localparam logic [7:0] OFF_STATUS    = 8'h24;
   localparam logic [7:0] OFF_IDENT     = 8'h28;

   // ----------------------------------------------------------------
   // Implemented bit masks of the four request and enable registers
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_REQ1     = 8'hC7;
   localparam logic [7:0] MASK_REQ2     = 8'h67;
   localparam logic [7:0] MASK_REQ3     = 8'h30;
   localparam logic [7:0] MASK_REQ4     = 8'hFF;

   // ----------------------------------------------------------------
   // Interrupt control field positions
   // ----------------------------------------------------------------
   localparam int         BIT_GLOBAL_EN = 7;
   localparam int         BIT_PERIPH_EN = 6;

   // ----------------------------------------------------------------
   // Status register field positions and reset values
   // ----------------------------------------------------------------
   localparam int         BIT_SLEEP_N   = 0;
   localparam int         BIT_WDOG_N    = 1;
   localparam int         BIT_ASLEEP    = 2;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic       RST_FLAG_N    = 1'b1;

   // ----------------------------------------------------------------
   // Vector and prefetch step of the core
   // ----------------------------------------------------------------
   localparam logic [15:0] IRQ_VECTOR   = 16'h0004;
   localparam logic [15:0] PC_STEP      = 16'h0001;

   // Identification value is arbitrary.
   localparam logic [31:0] IDENT_VALUE  = 32'h5A5A_0001;

   // Power state of the core, Gray coded along awake, entering, asleep, waking.
   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_ENTER = 2'b01,
      ST_SLEEP = 2'b11,
      ST_WAKE  = 2'b10
   } power_state_t;

endpackage : sleep_wake_pkg

// ---- src/sleep_wake_ctrl.sv ----
// Sleep entry, wake-up control and peripheral interrupt request flags with an APB slave.
//
// Functional notes
// - Flags set on event regardless of enables
// - Request register 1 layout, bits 5-3 zero
// - Request register 2 layout, bits 7,4,3 zero
// - Request register 3 layout, bits 5-4 only
// - Request register 4 layout, all eight bits
// - Flags read/write, read pending, reset zero
// - Sleep entered only by sleep instruction
// - Sleep entry clears watchdog, updates flags, stops clock
// - Low-frequency oscillator keeps running in sleep
// - Timer1 keeps running on sleep-capable clocks
// - Converter runs on dedicated oscillator in sleep
// - Pins hold their drive state while asleep
// - Sleep leaves resets other than watchdog alone
// - Resets reset; watchdog and interrupts resume
// - Next instruction prefetched during sleep instruction
// - Enabled source wakes regardless of global enable
// - Global enable set vectors after prefetched instruction
// - Watchdog cleared on every wake
// - Pending enabled flag turns sleep into no-op
// - Late flag completes sleep then wakes immediately
// - Peripheral delivery needs peripheral gate bit
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps

module sleep_wake_ctrl
   import sleep_wake_pkg::*;
#(
   parameter int PIN_COUNT = 12
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Peripheral event pulses, one per request register
   input  wire logic [7:0]           req1_event,
   input  wire logic [7:0]           req2_event,
   input  wire logic [7:0]           req3_event,
   input  wire logic [7:0]           req4_event,
   // Core-side sleep handshake
   input  wire logic                 sleep_exec,
   input  wire logic [15:0]          core_pc,
   input  wire logic                 watchdog_expired,
   input  wire logic                 ext_irq,
   output logic                      core_clk_en,
   output logic                      watchdog_clear,
   output logic                      resume_pulse,
   output logic                      vector_request,
   output logic      [15:0]          prefetch_addr,
   output logic      [15:0]          vector_addr,
   output logic                      irq_to_core,
   // Clock keep-alive indications for sleep-capable peripherals
   input  wire logic                 timer1_clk_sleep_ok,
   input  wire logic                 adc_rc_selected,
   output logic                      low_freq_osc_run,
   output logic                      timer1_run,
   output logic                      adc_run,
   // I/O pin drive from the core and held pin drive
   input  wire logic [PIN_COUNT-1:0] pin_out_core,
   input  wire logic [PIN_COUNT-1:0] pin_oe_core,
   output logic      [PIN_COUNT-1:0] pin_out,
   output logic      [PIN_COUNT-1:0] pin_oe
);

   // ----------------------------------------------------------------
   // Synchronisers for the asynchronous inputs
   // ----------------------------------------------------------------
   logic [1:0] wdog_sync;
   logic [1:0] ext_sync;
   wire        wdog_expired_s = wdog_sync[1];
   wire        ext_irq_s      = ext_sync[1];

   // Two flip-flops on each pin-level input before any logic reads it.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wdog_sync <= 2'b00;
         ext_sync  <= 2'b00;
      end else begin
         wdog_sync <= {wdog_sync[0], watchdog_expired};
         ext_sync  <= {ext_sync[0], ext_irq};
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]   req1, req2, req3, req4;
   logic [7:0]   en1, en2, en3, en4;
   logic [7:0]   intctl;
   logic         sleep_entered_flag_n;
   logic         watchdog_expiry_flag_n;
   power_state_t state;
   power_state_t next_state;
   logic [PIN_COUNT-1:0] held_out;
   logic [PIN_COUNT-1:0] held_oe;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire access    = psel & penable;
   wire wr        = access & pwrite;
   wire wr_req1   = wr & (paddr == OFF_REQ1);
   wire wr_req2   = wr & (paddr == OFF_REQ2);
   wire wr_req3   = wr & (paddr == OFF_REQ3);
   wire wr_req4   = wr & (paddr == OFF_REQ4);
   wire wr_en1    = wr & (paddr == OFF_EN1);
   wire wr_en2    = wr & (paddr == OFF_EN2);
   wire wr_en3    = wr & (paddr == OFF_EN3);
   wire wr_en4    = wr & (paddr == OFF_EN4);
   wire wr_intctl = wr & (paddr == OFF_INTCTL);
   wire mapped    = (paddr == OFF_REQ1) | (paddr == OFF_REQ2) | (paddr == OFF_REQ3)
                  | (paddr == OFF_REQ4) | (paddr == OFF_EN1) | (paddr == OFF_EN2)
                  | (paddr == OFF_EN3) | (paddr == OFF_EN4) | (paddr == OFF_INTCTL)
                  | (paddr == OFF_STATUS) | (paddr == OFF_IDENT);
   wire [7:0] wbyte = pwdata[7:0];

   // Zero-wait slave; unmapped addresses answer with an error.
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // ----------------------------------------------------------------
   // Request flags: a hardware event wins over a software write
   // ----------------------------------------------------------------
   wire [7:0] next_req1 = ((wr_req1 ? wbyte : req1) | req1_event) & MASK_REQ1;
   wire [7:0] next_req2 = ((wr_req2 ? wbyte : req2) | req2_event) & MASK_REQ2;
   wire [7:0] next_req3 = ((wr_req3 ? wbyte : req3) | req3_event) & MASK_REQ3;
   wire [7:0] next_req4 = ((wr_req4 ? wbyte : req4) | req4_event) & MASK_REQ4;

   // Flags are read/write and clear on every reset.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         req1 <= RST_BYTE;
         req2 <= RST_BYTE;
         req3 <= RST_BYTE;
         req4 <= RST_BYTE;
      end else begin
         req1 <= next_req1;
         req2 <= next_req2;
         req3 <= next_req3;
         req4 <= next_req4;
      end
   end

   // Enable and interrupt control registers written by software.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         en1    <= RST_BYTE;
         en2    <= RST_BYTE;
         en3    <= RST_BYTE;
         en4    <= RST_BYTE;
         intctl <= RST_BYTE;
      end else begin
         if (wr_en1)    en1    <= wbyte & MASK_REQ1;
         if (wr_en2)    en2    <= wbyte & MASK_REQ2;
         if (wr_en3)    en3    <= wbyte & MASK_REQ3;
         if (wr_en4)    en4    <= wbyte & MASK_REQ4;
         if (wr_intctl) intctl <= wbyte;
      end
   end

   // ----------------------------------------------------------------
   // Wake request and interrupt delivery
   // ----------------------------------------------------------------
   wire periph_pending = |(req1 & en1) | |(req2 & en2)
                       | |(req3 & en3) | |(req4 & en4);
   wire global_en      = intctl[BIT_GLOBAL_EN];
   wire periph_gate    = intctl[BIT_PERIPH_EN];
   wire wake_irq       = periph_pending | ext_irq_s;
   wire wake_any       = wake_irq | wdog_expired_s;

   // Peripheral requests reach the core only through the gate bit.
   assign irq_to_core = global_en & ((periph_pending & periph_gate) | ext_irq_s);

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   // A pending enabled request at the sleep instruction makes it a no-op.
   wire sleep_nop   = sleep_exec & wake_irq;
   wire sleep_start = sleep_exec & ~sleep_nop;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_AWAKE: if (sleep_start) next_state = ST_ENTER;
         ST_ENTER: next_state = wake_any ? ST_WAKE : ST_SLEEP;
         ST_SLEEP: if (wake_any) next_state = ST_WAKE;
         ST_WAKE:  next_state = ST_AWAKE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) state <= ST_AWAKE;
      else       state <= next_state;
   end

   // Status flags, active low, updated only on a completed sleep entry.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sleep_entered_flag_n   <= RST_FLAG_N;
         watchdog_expiry_flag_n <= RST_FLAG_N;
      end else if (sleep_start) begin
         sleep_entered_flag_n   <= 1'b0;
         watchdog_expiry_flag_n <= 1'b1;
      end
   end

   // Pin drive captured at sleep entry and held while the core sleeps.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         held_out <= '0;
         held_oe  <= '0;
      end else if (state == ST_AWAKE) begin
         held_out <= pin_out_core;
         held_oe  <= pin_oe_core;
      end
   end

   // Prefetch address and wake outputs registered from the core's state.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prefetch_addr  <= '0;
         resume_pulse   <= 1'b0;
         vector_request <= 1'b0;
         watchdog_clear <= 1'b0;
      end else begin
         if (sleep_exec) prefetch_addr <= core_pc + PC_STEP;
         resume_pulse   <= (next_state == ST_WAKE);
         vector_request <= (next_state == ST_WAKE) & global_en & wake_irq;
         watchdog_clear <= sleep_start | (next_state == ST_WAKE);
      end
   end

   // ----------------------------------------------------------------
   // Clock gating and keep-alive indications
   // ----------------------------------------------------------------
   wire asleep = (state == ST_SLEEP) | (state == ST_ENTER);
   assign core_clk_en      = ~asleep;
   assign low_freq_osc_run = 1'b1;
   assign timer1_run       = ~asleep | timer1_clk_sleep_ok;
   assign adc_run          = ~asleep | adc_rc_selected;
   assign vector_addr      = IRQ_VECTOR;
   assign pin_out          = asleep ? held_out : pin_out_core;
   assign pin_oe           = asleep ? held_oe  : pin_oe_core;

   // ----------------------------------------------------------------
   // Read data mux; sleep leaves register contents other than the status flags and resets alone
   // ----------------------------------------------------------------
   wire [7:0] status_byte = {5'b0, asleep, watchdog_expiry_flag_n, sleep_entered_flag_n};

   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         OFF_REQ1:   prdata[7:0] = req1;
         OFF_REQ2:   prdata[7:0] = req2;
         OFF_REQ3:   prdata[7:0] = req3;
         OFF_REQ4:   prdata[7:0] = req4;
         OFF_EN1:    prdata[7:0] = en1;
         OFF_EN2:    prdata[7:0] = en2;
         OFF_EN3:    prdata[7:0] = en3;
         OFF_EN4:    prdata[7:0] = en4;
         OFF_INTCTL: prdata[7:0] = intctl;
         OFF_STATUS: prdata[7:0] = status_byte;
         OFF_IDENT:  prdata      = IDENT_VALUE;
         default:    prdata      = 32'h0000_0000;
      endcase
   end

endmodule : sleep_wake_ctrl

// ---- verification/core_model.sv ----
// Behavioural core that issues sleep instructions and raises wake sources.
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Controller handshake
   input  wire logic        core_clk_en,
   output logic             sleep_exec,
   output logic [15:0]      core_pc,
   output logic             watchdog_expired,
   output logic             ext_irq
);
   initial begin
      sleep_exec = 1'b0;
      watchdog_expired = 1'b0;
      ext_irq = 1'b0;
   end

   // Program counter advances only while the core clock runs.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) core_pc <= 16'h0100;
      else if (core_clk_en) core_pc <= core_pc + 16'h0001;
   end

   // Sleep is only ever a one-cycle instruction; the slot after it is a no-op.
   task automatic exec_sleep();
      sleep_exec <= 1'b1;
      @(posedge sys_clk);
      sleep_exec <= 1'b0;
   endtask : exec_sleep

   // Wake sources are asynchronous levels held until told to drop.
   task automatic set_wake(input logic wd, input logic ex);
      watchdog_expired <= wd;
      ext_irq <= ex;
   endtask : set_wake
endmodule : core_model

// ---- verification/sleep_wake_ctrl_assertions.sv ----
// Port-level assertions for the sleep and wake controller.
`timescale 1ns/1ps
module sleep_wake_ctrl_assertions
   import sleep_wake_pkg::*;
#(
   parameter int PIN_COUNT = 12
) (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 reset,
   // Core side
   input wire logic                 sleep_exec,
   input wire logic [15:0]          core_pc,
   input wire logic                 core_clk_en,
   input wire logic                 watchdog_clear,
   input wire logic                 resume_pulse,
   input wire logic                 vector_request,
   input wire logic [15:0]          prefetch_addr,
   // Keep-alive and pins
   input wire logic                 timer1_clk_sleep_ok,
   input wire logic                 timer1_run,
   input wire logic                 low_freq_osc_run,
   input wire logic [PIN_COUNT-1:0] pin_out,
   input wire logic [PIN_COUNT-1:0] pin_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // Entry into sleep and what it must do on the way in.
   a_entry_by_instr: assert property ($fell(core_clk_en) |-> $past(sleep_exec))
      else $error("core clock stopped without a sleep instruction");
   a_entry_wdog_clr: assert property ($fell(core_clk_en) |-> watchdog_clear)
      else $error("watchdog not cleared at sleep entry");
   a_prefetch_next: assert property ($fell(core_clk_en) |->
      prefetch_addr == $past(core_pc) + PC_STEP)
      else $error("prefetch address is not the next instruction");
   // Clocks that keep running while asleep; timer1 only on a sleep-capable clock.
   a_lfosc_running: assert property (low_freq_osc_run)
      else $error("low frequency oscillator stopped");
   a_timer1_sleep: assert property (!core_clk_en |-> timer1_run == timer1_clk_sleep_ok)
      else $error("timer1 run state wrong while asleep");
   // Pin drive frozen once sleep is settled.
   a_pins_held: assert property (!core_clk_en && !$past(core_clk_en) &&
      !$past(core_clk_en, 2) |-> $stable(pin_out) && $stable(pin_oe))
      else $error("pin drive changed while asleep");
   // Wake-up sequence.
   a_wake_wdog_clr: assert property (resume_pulse |-> watchdog_clear)
      else $error("watchdog not cleared at wake");
   a_resume_order: assert property (resume_pulse |-> !$past(core_clk_en) ##1 core_clk_en)
      else $error("resume not from sleep or clock not restarted");
   a_vector_on_wake: assert property (vector_request |-> resume_pulse)
      else $error("vector request without a wake");
   a_resume_single: assert property (resume_pulse |=> !resume_pulse)
      else $error("resume pulse longer than one cycle");
endmodule : sleep_wake_ctrl_assertions

bind sleep_wake_ctrl sleep_wake_ctrl_assertions #(.PIN_COUNT(PIN_COUNT)) chk (
   .sys_clk, .reset, .sleep_exec, .core_pc, .core_clk_en, .watchdog_clear,
   .resume_pulse, .vector_request, .prefetch_addr, .timer1_clk_sleep_ok,
   .timer1_run, .low_freq_osc_run, .pin_out, .pin_oe
);

// ---- verification/test_sleep_wake_ctrl.sv ----
// Self-checking testbench of the sleep and wake controller.
`timescale 1ns/1ps
module test_sleep_wake_ctrl;
   import sleep_wake_pkg::*;
   localparam logic [7:0] MSK [4] = '{MASK_REQ1, MASK_REQ2, MASK_REQ3, MASK_REQ4};
   logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, v, b;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  ev [4];
   logic        sleep_exec, watchdog_expired, ext_irq, core_clk_en, watchdog_clear;
   logic        resume_pulse, vector_request, irq_to_core, e;
   logic [15:0] core_pc, prefetch_addr, vector_addr;
   logic        timer1_clk_sleep_ok, adc_rc_selected, low_freq_osc_run, timer1_run, adc_run;
   logic [11:0] pin_out_core, pin_oe_core, pin_out, pin_oe;
   int          errors = 0, checked = 0, cycles = 0, i, r;

   sleep_wake_ctrl DUT (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .req1_event(ev[0]), .req2_event(ev[1]),
      .req3_event(ev[2]), .req4_event(ev[3]), .sleep_exec, .core_pc,
      .watchdog_expired, .ext_irq, .core_clk_en, .watchdog_clear, .resume_pulse,
      .vector_request, .prefetch_addr, .vector_addr, .irq_to_core,
      .timer1_clk_sleep_ok, .adc_rc_selected, .low_freq_osc_run, .timer1_run,
      .adc_run, .pin_out_core, .pin_oe_core, .pin_out, .pin_oe);
   core_model core (.sys_clk, .reset, .core_clk_en, .sleep_exec, .core_pc,
      .watchdog_expired, .ext_irq);

   // Clock, random side inputs and the hang limit.
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      pin_out_core <= 12'($urandom);
      pin_oe_core <= 12'($urandom);
      timer1_clk_sleep_ok <= 1'($urandom);
      adc_rc_selected <= 1'($urandom);
      cycles++;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end

   function automatic logic [31:0] flag_exp(input int n, input logic [7:0] val);
      return {24'h000000, val & MSK[n]};
   endfunction : flag_exp
   task automatic check(input string name, input logic [31:0] x, input logic [31:0] got);
      checked++;
      if (got !== x) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, x, got);
      end
   endtask : check
   // One APB transfer, setup then access until ready, then one idle edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge sys_clk) penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 8'h00);
      check("prdata", x, q);
      check("pslverr", {31'h0, xe}, {31'h0, e});
   endtask : rd
   task automatic pulse(input int n, input logic [7:0] val);
      ev[n] <= val;
      @(posedge sys_clk) ev[n] <= 8'h00;
   endtask : pulse
   task automatic wait_wake(input logic vec);
      int k;
      k = 0;
      do begin @(posedge sys_clk); k++; end while (resume_pulse !== 1'b1 && k < 40);
      check("resume_pulse", 32'h1, {31'h0, resume_pulse});
      check("vector_request", {31'h0, vec}, {31'h0, vector_request});
      check("watchdog_clear", 32'h1, {31'h0, watchdog_clear});
   endtask : wait_wake
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   initial begin
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ev = '{8'h00, 8'h00, 8'h00, 8'h00};
      {pin_out_core, pin_oe_core, timer1_clk_sleep_ok, adc_rc_selected} = '0;
      void'($urandom(32'h03BB));
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      // Reset values, implemented bits, unmapped place.
      for (i = 0; i < 4; i++) begin
         rd(OFF_REQ1 + 8'(4*i), 32'h0, 1'b0);
         apb(1'b1, OFF_REQ1 + 8'(4*i), 8'hFF);
         rd(OFF_REQ1 + 8'(4*i), flag_exp(i, 8'hFF), 1'b0);
         apb(1'b1, OFF_REQ1 + 8'(4*i), 8'h00);
         v = 8'($urandom);
         pulse(i, v);
         rd(OFF_REQ1 + 8'(4*i), flag_exp(i, v), 1'b0);
         apb(1'b1, OFF_REQ1 + 8'(4*i), 8'h00);
         rd(OFF_REQ1 + 8'(4*i), 32'h0, 1'b0);
      end
      rd(OFF_STATUS, 32'h00000003, 1'b0);
      rd(8'h2C, 32'h0, 1'b1);
      check("vector_addr", 32'h00000004, {16'h0000, vector_addr});
      $display("test registers done");
      // Enabled flag already pending: sleep acts as a no-op.
      apb(1'b1, OFF_EN1, 8'h01);
      pulse(0, 8'h01);
      core.exec_sleep();
      repeat (3) @(posedge sys_clk);
      check("core_clk_en", 32'h1, {31'h0, core_clk_en});
      rd(OFF_STATUS, 32'h00000003, 1'b0);
      apb(1'b1, OFF_REQ1, 8'h00);
      $display("test sleep no-op done");
      // Flag arriving in sleep wakes at once, in line.
      core.exec_sleep();
      repeat (4) @(posedge sys_clk);
      check("core_clk_en", 32'h0, {31'h0, core_clk_en});
      check("adc_run", {31'h0, adc_rc_selected}, {31'h0, adc_run});
      rd(OFF_STATUS, 32'h00000006, 1'b0);
      pulse(0, 8'h01);
      wait_wake(1'b0);
      rd(OFF_STATUS, 32'h00000002, 1'b0);
      apb(1'b1, OFF_REQ1, 8'h00);
      apb(1'b1, OFF_EN1, 8'h00);
      $display("test late flag wake done");
      // Random source with global enable: vectored wake and the peripheral gate.
      r = $urandom % 4;
      b = 8'(MSK[r] & (~MSK[r] + 8'h01));
      apb(1'b1, OFF_INTCTL, 8'h80);
      apb(1'b1, OFF_EN1 + 8'(4*r), b);
      core.exec_sleep();
      repeat (3) @(posedge sys_clk);
      pulse(r, b);
      wait_wake(1'b1);
      @(posedge sys_clk);
      check("irq_to_core", 32'h0, {31'h0, irq_to_core});
      apb(1'b1, OFF_INTCTL, 8'hC0);
      check("irq_to_core", 32'h1, {31'h0, irq_to_core});
      apb(1'b1, OFF_REQ1 + 8'(4*r), 8'h00);
      apb(1'b1, OFF_EN1 + 8'(4*r), 8'h00);
      apb(1'b1, OFF_INTCTL, 8'h00);
      $display("test vectored wake done");
      // Disabled flags do not wake; watchdog then external line do.
      for (i = 1; i >= 0; i--) begin
         core.exec_sleep();
         repeat (3) @(posedge sys_clk);
         pulse(1, MASK_REQ2);
         repeat (10) @(posedge sys_clk);
         check("core_clk_en", 32'h0, {31'h0, core_clk_en});
         core.set_wake(1'(i), 1'(1 - i));
         wait_wake(1'b0);
         core.set_wake(1'b0, 1'b0);
         repeat (4) @(posedge sys_clk);
      end
      $display("test wake sources done");
      // Reset in mid-run clears flags and restores the status flags.
      pulse(3, MASK_REQ4);
      rd(OFF_REQ4, {24'h000000, MASK_REQ4}, 1'b0);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd(OFF_REQ4, 32'h0, 1'b0);
      rd(OFF_STATUS, 32'h00000003, 1'b0);
      $display("test mid-run reset done");
      test_done();
   end
endmodule : test_sleep_wake_ctrl
